// ==== common/sdc_defs.vh ====
`ifndef SDC_DEFS_VH
`define SDC_DEFS_VH

`define SDC_NUM_CH 6
`define SDC_WORD_W 10
`define SDC_FRAME_W 12
`define SDC_FRAME_LAST 4'hB
`define SDC_CLK_HIGH_BITS 4'h6
`define SDC_LOCK_WORDS 7'h50
`define SDC_MISS_LIMIT 2'h2

`define SDC_REG_CTRL 8'h00
`define SDC_REG_STATUS 8'h04
`define SDC_REG_ID 8'h08
`define SDC_REG_CHSTAT_BASE 3'h1
`define SDC_REG_CHWORD_BASE 3'h2

`define SDC_CTRL_SLEEP_LSB 0
`define SDC_CTRL_CLEAR_BIT 8
`define SDC_CTRL_RESET 6'h00

`define SDC_STAT_SLEEP_LSB 8
`define SDC_STAT_SCAN_BIT 16
`define SDC_STAT_GSLEEP_BIT 17
`define SDC_STAT_OE_BIT 18

`define SDC_RESP_OKAY 2'h0
`define SDC_RESP_SLVERR 2'h2

`endif

// ==== logic/sdc_channel.v ====
`timescale 1ns/1ps
`default_nettype none
`include "sdc_defs.vh"

module sdc_channel #(
  parameter WORD_W = `SDC_WORD_W,
  parameter [6:0] LOCK_WORDS = `SDC_LOCK_WORDS,
  parameter [1:0] MISS_LIMIT = `SDC_MISS_LIMIT
) (
  input wire core_clk,
  input wire rst_n,
  input wire clkEn,
  input wire sleep,
  input wire localReferenceStrobe,
  input wire serialIn,
  output reg [WORD_W-1:0] wordOut,
  output reg wordStrobe,
  output reg lossPulse,
  output wire recClk,
  output wire locked,
  output wire asleep
);
  localparam [2:0] ST_SLEEP = 3'h1;
  localparam [2:0] ST_HUNT = 3'h2;
  localparam [2:0] ST_LOCK = 3'h4;

  reg [2:0] state;
  reg [11:0] shiftReg;
  reg [3:0] bitPos;
  reg [6:0] goodCnt;
  reg [1:0] missCnt;

  // start bit high first, stop bit low last
  wire [11:0] frame = {serialIn, shiftReg[11:1]};
  wire frameEnd = (bitPos == `SDC_FRAME_LAST);
  wire frameOk = frame[0] & ~frame[11];

  assign locked = (state == ST_LOCK);
  assign asleep = (state == ST_SLEEP);
  // clock high over first half of each word, data changes on the same edge as the rise
  assign recClk = locked ? (bitPos < `SDC_CLK_HIGH_BITS) : 1'b1;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      state <= ST_SLEEP;
      shiftReg <= 12'hFFF;
      bitPos <= 4'h0;
      goodCnt <= 7'h00;
      missCnt <= 2'h0;
      wordOut <= {WORD_W{1'b1}};
      wordStrobe <= 1'b0;
      lossPulse <= 1'b0;
    end else if (clkEn) begin
      wordStrobe <= 1'b0;
      lossPulse <= 1'b0;
      case (state)
        ST_SLEEP: begin
          bitPos <= 4'h0;
          goodCnt <= 7'h00;
          missCnt <= 2'h0;
          if (!sleep) begin
            state <= ST_HUNT;
          end
        end
        ST_HUNT: begin
          if (sleep) begin
            state <= ST_SLEEP;
          end else if (localReferenceStrobe) begin
            shiftReg <= frame;
            if (!frameEnd) begin
              bitPos <= bitPos + 4'h1;
            end else if (frameOk) begin
              bitPos <= 4'h0;
              if (goodCnt == LOCK_WORDS - 7'h01) begin
                state <= ST_LOCK;
                goodCnt <= 7'h00;
                missCnt <= 2'h0;
              end else begin
                goodCnt <= goodCnt + 7'h01;
              end
            end else begin
              // slip one bit to hunt for the edge
              bitPos <= 4'h1;
              goodCnt <= 7'h00;
            end
          end
        end
        ST_LOCK: begin
          if (sleep) begin
            state <= ST_SLEEP;
          end else if (localReferenceStrobe) begin
            shiftReg <= frame;
            if (!frameEnd) begin
              bitPos <= bitPos + 4'h1;
            end else begin
              bitPos <= 4'h0;
              if (frameOk) begin
                wordOut <= frame[10:1];
                wordStrobe <= 1'b1;
                missCnt <= 2'h0;
              end else if (missCnt + 2'h1 == MISS_LIMIT) begin
                state <= ST_HUNT;
                lossPulse <= 1'b1;
                goodCnt <= 7'h00;
              end else begin
                missCnt <= missCnt + 2'h1;
              end
            end
          end
        end
        default: begin
          state <= ST_SLEEP;
        end
      endcase
    end
  end
endmodule // sdc_channel

`default_nettype wire

// ==== logic/sdc_out_ctrl.v ====
`timescale 1ns/1ps
`default_nettype none
`include "sdc_defs.vh"

module sdc_out_ctrl #(
  parameter WORD_W = `SDC_WORD_W
) (
  input wire core_clk,
  input wire rst_n,
  input wire clkEn,
  input wire scanOff,
  input wire globalAsleep,
  input wire chanAsleep,
  input wire outputEnable,
  input wire locked,
  input wire [WORD_W-1:0] wordIn,
  input wire clkIn,
  output reg [WORD_W-1:0] wordOut,
  output reg wordOe,
  output reg clkOut,
  output reg clkOe,
  output reg unlockedOut,
  output reg unlockedOe
);
  always @(posedge core_clk) begin
    if (!rst_n) begin
      wordOut <= {WORD_W{1'b1}};
      clkOut <= 1'b1;
      unlockedOut <= 1'b1;
      wordOe <= 1'b1;
      clkOe <= 1'b1;
      unlockedOe <= 1'b1;
    end else if (clkEn) begin
      // outputs high unless the channel is locked and awake
      wordOut <= {WORD_W{1'b1}};
      clkOut <= 1'b1;
      unlockedOut <= 1'b1;
      wordOe <= 1'b1;
      clkOe <= 1'b1;
      unlockedOe <= 1'b1;
      if (scanOff) begin
        wordOe <= 1'b0;
        clkOe <= 1'b0;
        unlockedOe <= 1'b0;
      end else if (globalAsleep) begin
        unlockedOut <= 1'b1;
      end else if (chanAsleep) begin
        unlockedOut <= 1'b1;
      end else begin
        unlockedOut <= ~locked;
        if (!outputEnable) begin
          wordOe <= 1'b0;
          clkOe <= 1'b0;
        end else if (locked) begin
          wordOut <= wordIn;
          clkOut <= clkIn;
        end
      end
    end
  end
endmodule // sdc_out_ctrl

`default_nettype wire

// ==== logic/sdc_top.v ====
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sdc_defs.vh"

module sdc_top #(
  parameter NUM_CH = `SDC_NUM_CH,
  parameter WORD_W = `SDC_WORD_W,
  parameter ADDR_W = 8,
  parameter [31:0] ID_VALUE = 32'h0000_1234 // arbitrary value
) (
  input wire core_clk,
  input wire rst_n,
  input wire clkEn,
  input wire globalSleepN,
  input wire [NUM_CH-1:0] channelSleepN,
  input wire outputEnable,
  input wire scanFloatN,
  input wire scanSelftestActive,
  input wire [NUM_CH-1:0] localReferenceStrobe,
  input wire [NUM_CH-1:0] serialIn,
  output wire [NUM_CH*WORD_W-1:0] parallelWordOut,
  output wire [NUM_CH-1:0] parallelWordOe,
  output wire [NUM_CH-1:0] recoveredWordClock,
  output wire [NUM_CH-1:0] recoveredWordClockOe,
  output wire [NUM_CH-1:0] channelUnlockedFlag,
  output wire [NUM_CH-1:0] channelUnlockedFlagOe,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  reg [5:0] swSleep;
  reg clearPulse;
  reg awHeld;
  reg wHeld;
  reg [ADDR_W-1:0] awAddrQ;
  reg [31:0] wDataQ;
  reg [3:0] wStrbQ;
  reg [31:0] rdData;
  reg rdHit;

  wire scanOff = ~scanFloatN | scanSelftestActive;
  wire globalAsleep = ~globalSleepN | ~(|channelSleepN);
  wire [NUM_CH-1:0] chLocked;
  wire [NUM_CH-1:0] chAsleep;
  wire [NUM_CH*32-1:0] chStatFlat;
  wire [NUM_CH*32-1:0] chWordFlat;

  // per-channel datapath, counters and pins
  genvar i;
  generate
    for (i = 0; i < NUM_CH; i = i + 1) begin : chan
      wire sleepReq;
      wire [WORD_W-1:0] word;
      wire wordStrobe;
      wire lossPulse;
      wire recClk;
      reg [7:0] lossCnt;
      reg [15:0] wordCnt;

      assign sleepReq = globalAsleep | ~channelSleepN[i] | swSleep[i];

      sdc_channel #(
        .WORD_W(WORD_W)
      ) u_channel (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .sleep(sleepReq),
        .localReferenceStrobe(localReferenceStrobe[i]),
        .serialIn(serialIn[i]),
        .wordOut(word),
        .wordStrobe(wordStrobe),
        .lossPulse(lossPulse),
        .recClk(recClk),
        .locked(chLocked[i]),
        .asleep(chAsleep[i])
      );

      sdc_out_ctrl #(
        .WORD_W(WORD_W)
      ) u_out (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .scanOff(scanOff),
        .globalAsleep(globalAsleep),
        .chanAsleep(sleepReq),
        .outputEnable(outputEnable),
        .locked(chLocked[i]),
        .wordIn(word),
        .clkIn(recClk),
        .wordOut(parallelWordOut[i*WORD_W +: WORD_W]),
        .wordOe(parallelWordOe[i]),
        .clkOut(recoveredWordClock[i]),
        .clkOe(recoveredWordClockOe[i]),
        .unlockedOut(channelUnlockedFlag[i]),
        .unlockedOe(channelUnlockedFlagOe[i])
      );

      // loss-of-lock and word counters, wrap around
      always @(posedge core_clk) begin
        if (!rst_n) begin
          lossCnt <= 8'h00;
          wordCnt <= 16'h0000;
        end else if (clkEn) begin
          if (clearPulse) begin
            lossCnt <= {7'h00, lossPulse};
            wordCnt <= {15'h0000, wordStrobe};
          end else begin
            lossCnt <= lossCnt + {7'h00, lossPulse};
            wordCnt <= wordCnt + {15'h0000, wordStrobe};
          end
        end
      end

      assign chStatFlat[i*32 +: 32] = {wordCnt, lossCnt, 6'h00, chAsleep[i], chLocked[i]};
      assign chWordFlat[i*32 +: 32] = {{(32-WORD_W){1'b0}}, word};
    end
  endgenerate

  // write channel: address and data in either order
  wire awFire = s_axi_awvalid & s_axi_awready;
  wire wFire = s_axi_wvalid & s_axi_wready;
  wire haveAw = awHeld | awFire;
  wire haveW = wHeld | wFire;
  wire [ADDR_W-1:0] wrAddr = awHeld ? awAddrQ : s_axi_awaddr;
  wire [31:0] wrData = wHeld ? wDataQ : s_axi_wdata;
  wire [3:0] wrStrb = wHeld ? wStrbQ : s_axi_wstrb;
  wire doWrite = haveAw & haveW & ~s_axi_bvalid;
  wire wrCtrl = (wrAddr == `SDC_REG_CTRL);

  assign s_axi_awready = clkEn & ~awHeld & ~s_axi_bvalid;
  assign s_axi_wready = clkEn & ~wHeld & ~s_axi_bvalid;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrQ <= {ADDR_W{1'b0}};
      wDataQ <= 32'h0000_0000;
      wStrbQ <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SDC_RESP_OKAY;
      swSleep <= `SDC_CTRL_RESET;
      clearPulse <= 1'b0;
    end else if (clkEn) begin
      clearPulse <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrCtrl ? `SDC_RESP_OKAY : `SDC_RESP_SLVERR;
        if (wrCtrl && wrStrb[0]) begin
          swSleep <= wrData[`SDC_CTRL_SLEEP_LSB +: 6];
        end
        if (wrCtrl && wrStrb[1]) begin
          clearPulse <= wrData[`SDC_CTRL_CLEAR_BIT];
        end
      end else begin
        if (awFire) begin
          awHeld <= 1'b1;
          awAddrQ <= s_axi_awaddr;
        end
        if (wFire) begin
          wHeld <= 1'b1;
          wDataQ <= s_axi_wdata;
          wStrbQ <= s_axi_wstrb;
        end
      end
    end
  end

  // read decode
  wire [2:0] rdIdx = s_axi_araddr[4:2];
  wire [2:0] rdBlock = s_axi_araddr[7:5];
  wire rdAligned = (s_axi_araddr[1:0] == 2'h0);
  wire rdChOk = rdAligned & (rdIdx < NUM_CH);

  always @* begin
    rdData = 32'h0000_0000;
    rdHit = 1'b1;
    if (s_axi_araddr == `SDC_REG_CTRL) begin
      rdData = {26'h0000000, swSleep};
    end else if (s_axi_araddr == `SDC_REG_STATUS) begin
      rdData = {13'h0000, outputEnable, globalAsleep, scanOff,
                2'h0, chAsleep, 2'h0, chLocked};
    end else if (s_axi_araddr == `SDC_REG_ID) begin
      rdData = ID_VALUE;
    end else if (rdChOk && rdBlock == `SDC_REG_CHSTAT_BASE) begin
      rdData = chStatFlat[rdIdx*32 +: 32];
    end else if (rdChOk && rdBlock == `SDC_REG_CHWORD_BASE) begin
      rdData = chWordFlat[rdIdx*32 +: 32];
    end else begin
      rdHit = 1'b0;
    end
  end

  assign s_axi_arready = clkEn & ~s_axi_rvalid;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SDC_RESP_OKAY;
    end else if (clkEn) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdData;
        s_axi_rresp <= rdHit ? `SDC_RESP_OKAY : `SDC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // sdc_top

`default_nettype wire

// ==== verification/sdc_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdc_monitor #(
  parameter NUM_CH = 6,
  parameter WORD_W = 10
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic globalSleepN,
  input wire logic [NUM_CH-1:0] channelSleepN,
  input wire logic outputEnable,
  input wire logic scanFloatN,
  input wire logic scanSelftestActive,
  input wire logic [NUM_CH-1:0] localReferenceStrobe,
  input wire logic [NUM_CH*WORD_W-1:0] parallelWordOut,
  input wire logic [NUM_CH-1:0] parallelWordOe,
  input wire logic [NUM_CH-1:0] recoveredWordClock,
  input wire logic [NUM_CH-1:0] recoveredWordClockOe,
  input wire logic [NUM_CH-1:0] channelUnlockedFlag,
  input wire logic [NUM_CH-1:0] channelUnlockedFlagOe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic scanOk;
  logic [15:0] huntCnt;
  assign scanOk = scanFloatN && !scanSelftestActive;
  // strobes seen on channel 0 while unlocked and awake
  always @(posedge core_clk) begin
    if (!rst_n || !channelUnlockedFlag[0] || !globalSleepN || !channelSleepN[0])
      huntCnt <= 16'h0000;
    else if (localReferenceStrobe[0] && huntCnt != 16'hFFFF)
      huntCnt <= huntCnt + 16'h0001;
  end
  scan_float_a: assert property (
    clkEn && !scanOk |=> !(|{parallelWordOe, recoveredWordClockOe, channelUnlockedFlagOe}))
    else $error("outputs driven under scan");
  gsleep_high_a: assert property (
    clkEn && scanOk && (!globalSleepN || channelSleepN == '0) |=>
    &{channelUnlockedFlag, recoveredWordClock, parallelWordOut, parallelWordOe})
    else $error("global sleep outputs not high");
  ch_sleep_a: assert property (
    clkEn && scanOk |=> ((~channelUnlockedFlag | ~recoveredWordClock | ~parallelWordOe)
    & ~$past(channelSleepN)) == '0)
    else $error("sleeping channel not high");
  oe_low_a: assert property (
    clkEn && scanOk && globalSleepN && channelSleepN != '0 && !outputEnable
    |=> ((parallelWordOe | recoveredWordClockOe) & $past(channelSleepN)) == '0)
    else $error("data not floated");
  flag_driven_a: assert property (
    clkEn && scanOk |=> &channelUnlockedFlagOe)
    else $error("unlocked flag floated");
  unlocked_high_a: assert property (
    channelUnlockedFlag[0] && parallelWordOe[0] |->
    &parallelWordOut[WORD_W-1:0] && (channelUnlockedFlag & parallelWordOe & ~recoveredWordClock) == '0)
    else $error("unlocked outputs not high");
  run_gate_a: assert property (
    !channelUnlockedFlag[0] && channelUnlockedFlagOe[0] |-> $past(globalSleepN) && $past(channelSleepN[0]))
    else $error("locked while asleep");
  // one strobe may precede the flag rising
  lock_time_a: assert property (
    $fell(channelUnlockedFlag[0]) && $past(channelUnlockedFlagOe[0]) |-> huntCnt >= 16'h03BF)
    else $error("lock declared too early");
endmodule // sdc_monitor
bind sdc_top sdc_monitor #(.NUM_CH(NUM_CH), .WORD_W(WORD_W)) mon (.core_clk, .rst_n, .clkEn,
  .globalSleepN, .channelSleepN, .outputEnable, .scanFloatN, .scanSelftestActive,
  .localReferenceStrobe, .parallelWordOut, .parallelWordOe, .recoveredWordClock,
  .recoveredWordClockOe, .channelUnlockedFlag, .channelUnlockedFlagOe);
`default_nettype wire

// ==== verification/sdc_serializer_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdc_serializer_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic syncReq,
  input wire logic corrupt,
  input wire logic [9:0] txWord,
  output logic strobe,
  output logic serialBit,
  output logic frameDone
);
  logic [3:0] bitPos;
  logic [11:0] frame;
  initial serialBit = 1'b0;
  // one strobe per bit at the sender's own rate, word rate in range
  always @(posedge core_clk) begin
    if (!rst_n || !run) begin
      bitPos <= 4'h0;
      strobe <= 1'b0;
      frameDone <= 1'b0;
      serialBit <= ~serialBit;
    end else begin
      strobe <= 1'b1;
      frameDone <= bitPos == 4'hA;
      bitPos <= (bitPos == 4'hB) ? 4'h0 : bitPos + 4'h1;
      if (bitPos == 4'h0) begin
        frame <= {corrupt, syncReq ? 10'h01F : txWord, 1'b1};
        serialBit <= 1'b1;
      end else begin
        serialBit <= frame[bitPos];
      end
    end
  end
endmodule // sdc_serializer_model
`default_nettype wire

// ==== verification/tb_six_channel_deserializer_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_six_channel_deserializer_control;
  logic core_clk = 1'b0, rst_n = 1'b0, globalSleepN = 1'b0, outputEnable = 1'b0;
  logic scanFloatN = 1'b1, scanSelftestActive = 1'b0, corrupt = 1'b0, run = 1'b0;
  logic [5:0] channelSleepN = 6'h00;
  logic [9:0] txWord = 10'h2C5;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000, rd;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [1:0] rs;
  wire strobe, serialBit, frameDone, s_axi_awready, s_axi_wready, s_axi_arready;
  wire s_axi_bvalid, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [59:0] parallelWordOut;
  wire [5:0] parallelWordOe, recoveredWordClock, recoveredWordClockOe;
  wire [5:0] channelUnlockedFlag, channelUnlockedFlagOe;
  int fail_count = 0, checked = 0, cyc = 0, n;
  initial forever #10 core_clk = ~core_clk;
  sdc_serializer_model partner (.core_clk, .rst_n, .run, .syncReq(channelUnlockedFlag[0]),
    .corrupt, .txWord, .strobe, .serialBit, .frameDone);
  sdc_top dut (.core_clk, .rst_n, .clkEn(1'b1), .globalSleepN, .channelSleepN, .outputEnable,
    .scanFloatN, .scanSelftestActive, .localReferenceStrobe({6{strobe}}),
    .serialIn({6{serialBit}}), .parallelWordOut, .parallelWordOe, .recoveredWordClock,
    .recoveredWordClockOe, .channelUnlockedFlag, .channelUnlockedFlagOe, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready(1'b1));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  task automatic wait_flag(input int ch, input logic v);
    n = 0;
    while (channelUnlockedFlag[ch] !== v && n < 4000) begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task automatic frames_bad(input int k);
    do @(posedge core_clk); while (frameDone !== 1'b1);
    corrupt <= 1'b1;
    repeat (k) do @(posedge core_clk); while (frameDone !== 1'b1);
    corrupt <= 1'b0;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, done;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      rs = s_axi_bresp;
      if (aw)
        s_axi_awvalid <= 1'b0;
      if (w)
        s_axi_wvalid <= 1'b0;
    end while (!done);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ar, done;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      ar = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      if (ar)
        s_axi_arvalid <= 1'b0;
    end while (!done);
  endtask
  task automatic t_lock();
    logic rc;
    globalSleepN <= 1'b1;
    channelSleepN <= 6'h3F;
    outputEnable <= 1'b1;
    run <= 1'b1;
    wait_flag(0, 1'b0);
    check(n >= 960, 1'b1);
    step(30);
    for (int i = 0; i < 6; i++) check(parallelWordOut[i*10+:10], txWord);
    n = 0;
    repeat (24) begin
      rc = recoveredWordClock[0];
      @(posedge core_clk);
      n += (!rc && recoveredWordClock[0]);
    end
    check(n, 2);
  endtask
  task automatic t_oe();
    outputEnable <= 1'b0;
    step(3);
    check({parallelWordOe, recoveredWordClockOe, channelUnlockedFlag, channelUnlockedFlagOe},
      24'h00003F);
    outputEnable <= 1'b1;
    step(3);
    check({parallelWordOe, parallelWordOut[9:0]}, {6'h3F, txWord});
  endtask
  task automatic t_loss();
    frames_bad(1);
    step(30);
    check(channelUnlockedFlag, 6'h00);
    frames_bad(2);
    step(30);
    check({channelUnlockedFlag, parallelWordOut[9:0]}, 16'hFFFF);
    wait_flag(0, 1'b0);
    step(30);
    check(channelUnlockedFlag, 6'h00);
  endtask
  task automatic t_sleep();
    channelSleepN <= 6'h3D;
    outputEnable <= 1'b0;
    step(3);
    check({channelUnlockedFlag, parallelWordOe, parallelWordOut[19:10]}, 22'h020BFF);
    outputEnable <= 1'b1;
    channelSleepN <= 6'h3F;
    wait_flag(1, 1'b0);
    check(n >= 960, 1'b1);
  endtask
  task automatic t_regs();
    axi_rd(8'h04);
    check(rd, 32'h0004003F);
    axi_wr(8'h00, 32'h00000004);
    step(3);
    check(channelUnlockedFlag, 6'h04);
    axi_rd(8'h00);
    check(rd, 32'h00000004);
    axi_wr(8'h00, 32'h00000000);
    axi_wr(8'h10, 32'h00000001);
    check(rs, 2'h2);
    axi_rd(8'h0C);
    check({rs, rd[29:0]}, 32'h80000000);
    wait_flag(2, 1'b0);
    check(channelUnlockedFlag, 6'h00);
  endtask
  task automatic t_global();
    globalSleepN <= 1'b0;
    step(3);
    check({channelUnlockedFlag, recoveredWordClock, parallelWordOe}, 18'h3FFFF);
    globalSleepN <= 1'b1;
    channelSleepN <= 6'h00;
    step(3);
    check({channelUnlockedFlag, recoveredWordClock, parallelWordOut[59:50]}, 22'h3FFFFF);
    scanFloatN <= 1'b0;
    step(3);
    check({parallelWordOe, recoveredWordClockOe, channelUnlockedFlagOe}, 18'h00000);
    scanFloatN <= 1'b1;
    scanSelftestActive <= 1'b1;
    step(3);
    check({parallelWordOe, recoveredWordClockOe, channelUnlockedFlagOe}, 18'h00000);
    scanSelftestActive <= 1'b0;
    run <= 1'b0;
  endtask
  initial begin
    step(16);
    rst_n <= 1'b1;
    step(2);
    check({channelUnlockedFlag, recoveredWordClock, parallelWordOut[9:0]}, 22'h3FFFFF);
    t_lock();
    t_oe();
    t_loss();
    t_sleep();
    t_regs();
    t_global();
    step(4);
    wrap_up();
  end
endmodule // tb_six_channel_deserializer_control
`default_nettype wire
